// ### verilog/frg_pkg.sv
package frg_pkg;
	// Register map
	localparam logic [19:0] DFL_CTRL_ADDR = 20'hf0090;
	localparam logic [7:0] DFL_CTRL_RESET = 8'h00;
	localparam int DFL_EN_BIT = 0;
	// Boot cluster 0 covers 00000H to 00fffH
	localparam logic [19:0] BOOT0_LO = 20'h00000;
	localparam logic [19:0] BOOT0_HI = 20'h00fff;
	// Code flash block size is 1 KB (address bits 19:10 give the block)
	localparam int BLK_SHIFT = 10;
	// Data flash erase block is 1 KB
	localparam int DF_BLK_BYTES = 1024;
	// Setup times in ns per flash operation mode
	localparam int CLK_NS = 20;
	localparam int SETUP_HS_NS = 5000;
	localparam int SETUP_LS_NS = 720;
	localparam int SETUP_LV_NS = 10000;
	localparam int SETUP_HS_CYC = (SETUP_HS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_LS_CYC = (SETUP_LS_NS + CLK_NS - 1) / CLK_NS;
	localparam int SETUP_LV_CYC = (SETUP_LV_NS + CLK_NS - 1) / CLK_NS;

	typedef enum logic [1:0] {
		FRG_HS,
		FRG_LS,
		FRG_LV
	} frg_fmode_t;

	typedef enum logic [1:0] {
		FRG_OP_NONE,
		FRG_OP_ERASE,
		FRG_OP_WRITE
	} frg_op_t;

	// Flash rewrite request from either requester
	typedef struct packed {
		logic valid;
		frg_op_t op;
		logic serial; // 1 serial programmer, 0 self-programming
		logic data_area; // 1 data flash, 0 code flash
		logic [19:0] addr;
	} frg_req_t;

	// Security settings request
	typedef struct packed {
		logic valid;
		logic serial;
		logic set_erase_pro;
		logic set_write_pro;
		logic set_boot0_pro;
		logic release_write_pro;
	} frg_sec_t;

	typedef struct packed {
		logic erase_pro;
		logic write_pro;
		logic boot0_pro;
	} frg_prot_t;
endpackage

// ### verilog/frg_sync.sv
`timescale 1ns/1ns
// Two-flop synchroniser for pin-level inputs
module frg_sync #(
	parameter int W = 1
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} frg_sync_st_t;

	frg_sync_st_t st;
	frg_sync_st_t next_st;

	// First stage feeds only the second
	always_comb begin
		next_st.s1 = i_d;
		next_st.s2 = st.s1;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_q = st.s2;
endmodule

// ### verilog/frg_setup_timer.sv
`timescale 1ns/1ns
// Counts the data flash setup time after the access enable rises
module frg_setup_timer #(
	parameter int CW = 10
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_enable,
	input wire logic [CW-1:0] i_load,
	output logic o_ready
);
	typedef struct packed {
		logic en_d;
		logic ready;
		logic [CW-1:0] cnt;
	} frg_tmr_st_t;

	frg_tmr_st_t st;
	frg_tmr_st_t next_st;

	// Reload on rising enable; ready only when the count has drained
	always_comb begin
		next_st = st;
		next_st.en_d = i_enable;
		if (!i_enable) begin
			next_st.ready = 1'b0;
			next_st.cnt = '0;
		end else if (!st.en_d) begin
			next_st.cnt = i_load;
			next_st.ready = 1'b0;
		end else if (st.cnt > 1) begin
			next_st.cnt = st.cnt - 1'b1;
		end else begin
			next_st.ready = 1'b1;
		end
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign o_ready = st.ready;
endmodule

// ### verilog/frg_guard.sv
`timescale 1ns/1ns
// Behaviour
// - Self-programming code write/erase outside the shield window is refused.
// - Window start/end blocks are set from either programming mode.
// - Serial programming ignores the window for erase and write.
// - Boot cluster 0 protection overrides an overlapping window.
// - The window checks code flash only, never data flash.
// - Erase protection refuses serial block erase; self erase still allowed.
// - Write protection refuses serial writes; self writes still allowed.
// - Write protection release is usable only after a reset following set.
// - Boot0 protection refuses rewrite of 00000H-00FFFH in both modes.
// - Protections clear when shipped; set independently from either mode.
// - Erase and boot0 protections are permanent once set.
// - Write release needs no other protection and both areas blank.
// - Write release is refused from self-programming.
// - Data flash erase is in whole 1 KB blocks.
// - Data flash reads and writes are single-byte only.
// - No fetch from data flash; code fetch allowed during background rewrite.
// - Data flash access blocked during code flash self-rewrite.
// - Control register is frozen and STOP denied during data rewrite.
// - Control register resets to zero, data flash stopped.
// - Control register takes bit or byte writes; bits 7-1 read zero.
// - Access enable at one enables data flash access.
// - Access withheld for the mode-dependent setup time after enabling.
module frg_guard #(
	parameter int CW = 10
) (
	input wire logic i_clk,
	input wire logic i_rst_n,
	// Register port of the CPU
	input wire logic i_reg_wr,
	input wire logic i_reg_bit, // 1 bit write, else byte write
	input wire logic [2:0] i_reg_bitpos,
	input wire logic [19:0] i_reg_addr,
	input wire logic [7:0] i_reg_wdata,
	output logic [7:0] o_reg_rdata,
	// Window setting
	input wire logic i_win_set,
	input wire logic [9:0] i_win_start,
	input wire logic [9:0] i_win_end,
	// Rewrite requests
	input wire frg_pkg::frg_req_t i_req,
	input wire frg_pkg::frg_sec_t i_sec,
	input wire logic i_code_blank,
	input wire logic i_data_blank,
	input wire logic i_self_prog_busy,
	input wire logic i_bg_rewrite, // Data flash rewrite in background
	input wire frg_pkg::frg_fmode_t i_fmode,
	// Persistent protection state from the flash extra area
	input wire frg_pkg::frg_prot_t i_prot_nv,
	// CPU data flash accesses
	input wire logic i_df_acc,
	input wire logic i_df_fetch,
	input wire logic [1:0] i_df_size, // 0 byte, 1 word, 2 dword
	input wire logic i_stop_req,
	output logic o_req_ok,
	output logic o_req_err,
	output logic [9:0] o_erase_blk,
	output logic o_df_grant,
	output logic o_df_err,
	output logic o_stop_ok,
	output frg_pkg::frg_prot_t o_prot,
	output logic [9:0] o_win_start,
	output logic [9:0] o_win_end,
	output logic o_write_rel_armed
);
	typedef struct packed {
		logic [7:0] ctrl;
		frg_pkg::frg_prot_t prot;
		logic [9:0] win_start;
		logic [9:0] win_end;
		logic rel_armed;
		logic loaded;
		logic req_ok;
		logic req_err;
		logic [9:0] erase_blk;
		logic df_grant;
		logic df_err;
		logic stop_ok;
	} frg_state_t;

	frg_state_t st;
	frg_state_t next_st;
	logic setup_ready;
	logic [CW-1:0] setup_load;
	logic bg_sync;

	// Block index of a flash address
	function automatic logic [9:0] blk_of(input logic [19:0] a);
		blk_of = a[19:frg_pkg::BLK_SHIFT];
	endfunction

	// Address falls in boot cluster 0
	function automatic logic in_boot0(input logic [19:0] a);
		in_boot0 = (a >= frg_pkg::BOOT0_LO) && (a <= frg_pkg::BOOT0_HI);
	endfunction

	// Setup wait per operating mode
	always_comb begin
		unique case (i_fmode)
			frg_pkg::FRG_HS: setup_load = CW'(frg_pkg::SETUP_HS_CYC);
			frg_pkg::FRG_LS: setup_load = CW'(frg_pkg::SETUP_LS_CYC);
			frg_pkg::FRG_LV: setup_load = CW'(frg_pkg::SETUP_LV_CYC);
			default: setup_load = CW'(frg_pkg::SETUP_LV_CYC);
		endcase
	end

	// Background busy is raised by the flash macro; synchronise it
	frg_sync #(.W(1)) u_sync (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_d(i_bg_rewrite),
		.o_q(bg_sync)
	);

	frg_setup_timer #(.CW(CW)) u_timer (
		.i_clk(i_clk),
		.i_rst_n(i_rst_n),
		.i_enable(st.ctrl[frg_pkg::DFL_EN_BIT]),
		.i_load(setup_load),
		.o_ready(setup_ready)
	);

	// Main decision logic
	always_comb begin
		logic refuse;
		logic code_op;
		logic in_win;
		next_st = st;
		refuse = 1'b0;
		code_op = 1'b0;
		in_win = 1'b0;
		next_st.req_ok = 1'b0;
		next_st.req_err = 1'b0;
		next_st.loaded = 1'b1;

		// Load nonvolatile protections once after reset
		if (!st.loaded) begin
			next_st.prot = i_prot_nv;
		end

		// Control register: frozen while data flash is rewriting
		if (i_reg_wr && i_reg_addr == frg_pkg::DFL_CTRL_ADDR && !bg_sync) begin
			if (i_reg_bit) begin
				if (i_reg_bitpos == 3'(frg_pkg::DFL_EN_BIT)) begin
					next_st.ctrl[frg_pkg::DFL_EN_BIT] = i_reg_wdata[0];
				end
			end else begin
				next_st.ctrl[frg_pkg::DFL_EN_BIT] = i_reg_wdata[0];
			end
		end

		// Window may be changed from either mode
		if (i_win_set) begin
			next_st.win_start = i_win_start;
			next_st.win_end = i_win_end;
		end

		// Security set: any combination, sticky bits
		if (i_sec.valid) begin
			if (i_sec.set_erase_pro) begin
				next_st.prot.erase_pro = 1'b1;
			end
			if (i_sec.set_boot0_pro) begin
				next_st.prot.boot0_pro = 1'b1;
			end
			if (i_sec.set_write_pro) begin
				next_st.prot.write_pro = 1'b1;
				// A fresh set needs a fresh reset before release works
				next_st.rel_armed = 1'b0;
			end
			// Release of write protection
			if (i_sec.release_write_pro && !i_sec.set_write_pro) begin
				if (i_sec.serial && st.rel_armed && st.loaded
					&& !st.prot.erase_pro && !st.prot.boot0_pro
					&& i_code_blank && i_data_blank) begin
					next_st.prot.write_pro = 1'b0;
				end
			end
		end
		// Erase and boot0 protections have no clear path at all
		// Release armed only by a reset that saw the protection set
		if (!st.loaded) begin
			next_st.rel_armed = i_prot_nv.write_pro;
		end

		// Rewrite request checks
		if (i_req.valid && i_req.op != frg_pkg::FRG_OP_NONE) begin
			code_op = !i_req.data_area;
			in_win = blk_of(i_req.addr) >= st.win_start
				&& blk_of(i_req.addr) <= st.win_end;
			if (code_op && !i_req.serial && !in_win) begin
				refuse = 1'b1;
			end
			if (code_op && in_boot0(i_req.addr) && st.prot.boot0_pro) begin
				refuse = 1'b1;
			end
			if (code_op && i_req.serial && st.prot.erase_pro
				&& i_req.op == frg_pkg::FRG_OP_ERASE) begin
				refuse = 1'b1;
			end
			if (code_op && i_req.serial && st.prot.write_pro
				&& i_req.op == frg_pkg::FRG_OP_WRITE) begin
				refuse = 1'b1;
			end
			next_st.req_ok = !refuse;
			next_st.req_err = refuse;
			// Data flash erase always rounds to its 1 KB block
			next_st.erase_blk = blk_of(i_req.addr);
		end

		// Data flash CPU access gating
		next_st.df_grant = 1'b0;
		next_st.df_err = 1'b0;
		if (i_df_acc || i_df_fetch) begin
			if (i_df_fetch || i_df_size != 2'h0
				|| i_self_prog_busy
				|| !st.ctrl[frg_pkg::DFL_EN_BIT] || !setup_ready) begin
				next_st.df_err = 1'b1;
			end else begin
				next_st.df_grant = 1'b1;
			end
		end
		// STOP allowed only when no background rewrite
		next_st.stop_ok = i_stop_req && !bg_sync;
	end

	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			st <= '0;
			st.ctrl <= frg_pkg::DFL_CTRL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// Outputs straight from flops; code fetch never gated here
	assign o_reg_rdata = {7'h00, st.ctrl[frg_pkg::DFL_EN_BIT]};
	assign o_req_ok = st.req_ok;
	assign o_req_err = st.req_err;
	assign o_erase_blk = st.erase_blk;
	assign o_df_grant = st.df_grant;
	assign o_df_err = st.df_err;
	assign o_stop_ok = st.stop_ok;
	assign o_prot = st.prot;
	assign o_win_start = st.win_start;
	assign o_win_end = st.win_end;
	assign o_write_rel_armed = st.rel_armed;

	// Assertions: every answer is registered, so checks except ctrl_zero_a look one cycle on
	boot0_guard_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && !i_req.data_area && i_req.op != frg_pkg::FRG_OP_NONE
		&& in_boot0(i_req.addr) && st.prot.boot0_pro |=> o_req_err)
		else $error("boot0 rewrite not refused");
	window_self_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && !i_req.serial && !i_req.data_area
		&& i_req.op != frg_pkg::FRG_OP_NONE
		&& blk_of(i_req.addr) > st.win_end |=> o_req_err)
		else $error("out of window not refused");
	window_low_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && !i_req.serial && !i_req.data_area
		&& i_req.op != frg_pkg::FRG_OP_NONE
		&& blk_of(i_req.addr) < st.win_start |=> o_req_err)
		else $error("below window not refused");
	serial_nowin_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.serial && !i_req.data_area
		&& !st.prot.boot0_pro
		&& ((i_req.op == frg_pkg::FRG_OP_ERASE && !st.prot.erase_pro)
		|| (i_req.op == frg_pkg::FRG_OP_WRITE && !st.prot.write_pro))
		|=> o_req_ok)
		else $error("serial rewrite refused without cause");
	data_nowin_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.data_area && i_req.op != frg_pkg::FRG_OP_NONE
		|=> o_req_ok)
		else $error("data flash refused");
	serial_erase_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.serial && !i_req.data_area
		&& i_req.op == frg_pkg::FRG_OP_ERASE && st.prot.erase_pro
		|=> o_req_err)
		else $error("serial erase not refused");
	serial_write_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.serial && !i_req.data_area
		&& i_req.op == frg_pkg::FRG_OP_WRITE && st.prot.write_pro
		|=> o_req_err)
		else $error("serial write not refused");
	one_answer_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_req.valid && i_req.op != frg_pkg::FRG_OP_NONE
		|=> o_req_ok != o_req_err)
		else $error("request without exactly one answer");
	erase_perm_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded && st.prot.erase_pro |=> st.prot.erase_pro)
		else $error("erase protection cleared");
	boot0_perm_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded && st.prot.boot0_pro |=> st.prot.boot0_pro)
		else $error("boot0 protection cleared");
	rel_cond_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded && st.prot.write_pro && (st.prot.erase_pro
		|| st.prot.boot0_pro || !i_code_blank || !i_data_blank)
		|=> st.prot.write_pro)
		else $error("write protection released too early");
	rel_arm_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded |=> !$rose(st.rel_armed))
		else $error("release armed without a reset");
	rel_disarm_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded && i_sec.valid && i_sec.set_write_pro |=> !st.rel_armed)
		else $error("release still armed after a new set");
	self_rel_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		st.loaded && i_sec.valid && !i_sec.serial && st.prot.write_pro
		|=> st.prot.write_pro)
		else $error("self mode released write protection");
	ctrl_zero_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		o_reg_rdata[7:1] == 7'h00)
		else $error("reserved bits nonzero");
	fetch_deny_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_df_fetch |=> !o_df_grant && o_df_err)
		else $error("fetch from data flash granted");
	size_deny_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_df_acc && i_df_size != 2'h0 |=> o_df_err && !o_df_grant)
		else $error("wide data flash access granted");
	off_deny_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_df_acc && !st.ctrl[frg_pkg::DFL_EN_BIT] |=> !o_df_grant)
		else $error("access granted while disabled");
	sp_block_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_df_acc && i_self_prog_busy |=> !o_df_grant)
		else $error("data flash access during self rewrite");
	setup_wait_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		i_df_acc && !setup_ready |=> o_df_err && !o_df_grant)
		else $error("access granted inside setup time");
	ctrl_frozen_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		bg_sync |=> $stable(st.ctrl))
		else $error("control register changed during rewrite");
	stop_deny_a: assert property (
		@(posedge i_clk) disable iff (!i_rst_n)
		bg_sync |=> !o_stop_ok)
		else $error("STOP allowed during background rewrite");
endmodule

// ### dv/frg_flash_model.sv
`timescale 1ns/1ns
// Far-side flash array: tracks whether each area still holds only blanks
module frg_flash_model (
	input wire logic i_clk,
	input wire logic i_wipe,
	input wire frg_pkg::frg_req_t i_req,
	input wire logic i_ok,
	output logic o_code_blank,
	output logic o_data_blank
);
	frg_pkg::frg_req_t last;
	// Only granted writes dirty an area; refused ones leave it as it was
	always @(posedge i_clk) begin
		if (i_req.valid) last <= i_req;
		if (i_wipe) begin
			o_code_blank <= 1'b1;
			o_data_blank <= 1'b1;
		end else if (i_ok && last.op == frg_pkg::FRG_OP_WRITE) begin
			if (last.data_area) o_data_blank <= 1'b0;
			else o_code_blank <= 1'b0;
		end
	end
endmodule

// ### dv/test_flash_rewrite_guard.sv
`timescale 1ns/1ns
// Self-checking bench; a small integer model predicts rewrite, security and register outcomes; data flash and STOP results are set per call
module test_flash_rewrite_guard;
	logic i_clk = 0, i_rst_n = 0, i_reg_wr, i_reg_bit, i_win_set;
	logic [2:0] i_reg_bitpos;
	logic [19:0] i_reg_addr;
	logic [7:0] i_reg_wdata, o_reg_rdata;
	logic [9:0] i_win_start, i_win_end, o_win_start, o_win_end, o_erase_blk;
	frg_pkg::frg_req_t i_req;
	frg_pkg::frg_sec_t i_sec;
	frg_pkg::frg_fmode_t i_fmode;
	frg_pkg::frg_prot_t i_prot_nv, o_prot;
	logic i_code_blank, i_data_blank, i_self_prog_busy, i_bg_rewrite;
	logic i_df_acc, i_df_fetch, i_stop_req, wipe;
	logic [1:0] i_df_size;
	logic o_req_ok, o_req_err, o_df_grant, o_df_err, o_stop_ok;
	logic o_write_rel_armed;
	int failures = 0, num_checks = 0, ws, we, r;
	bit pe, pw, pb, armed, data_flash_access_enable;

	frg_guard u_dut (.i_clk, .i_rst_n, .i_reg_wr, .i_reg_bit, .i_reg_bitpos,
		.i_reg_addr, .i_reg_wdata, .o_reg_rdata, .i_win_set, .i_win_start,
		.i_win_end, .i_req, .i_sec, .i_code_blank, .i_data_blank,
		.i_self_prog_busy, .i_bg_rewrite, .i_fmode, .i_prot_nv, .i_df_acc,
		.i_df_fetch, .i_df_size, .i_stop_req, .o_req_ok, .o_req_err,
		.o_erase_blk, .o_df_grant, .o_df_err, .o_stop_ok, .o_prot,
		.o_win_start, .o_win_end, .o_write_rel_armed);
	frg_flash_model u_flash (.i_clk, .i_wipe(wipe), .i_req, .i_ok(o_req_ok),
		.o_code_blank(i_code_blank), .o_data_blank(i_data_blank));

	always #10 i_clk = ~i_clk;

	task automatic chk(logic [31:0] g, logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			failures++;
			$display("CHECK FAILED t=%0t got %h exp %h", $time, g, e);
		end
	endtask

	// Reference verdict for one rewrite request
	function automatic bit exp_ok(int op, bit s, bit d, logic [19:0] a);
		if (d) return 1;
		if (pb && a <= 20'h00fff) return 0;
		if (s) return !(op == 1 && pe) && !(op == 2 && pw);
		return a[19:10] >= ws && a[19:10] <= we;
	endfunction

	// Answers may land one or two falling edges after the request
	task automatic do_req(int op, bit s, bit d, logic [19:0] a);
		bit ok;
		ok = exp_ok(op, s, d, a);
		i_req = '{1'b1, frg_pkg::frg_op_t'(op), s, d, a};
		@(negedge i_clk);
		i_req.valid = 0;
		if (!(o_req_ok | o_req_err)) @(negedge i_clk);
		chk({o_req_ok, o_req_err}, {ok, !ok});
		chk(o_erase_blk, a[19:10]);
		@(negedge i_clk);
	endtask

	task automatic do_sec(bit s, bit e, bit w, bit b, bit rl);
		i_sec = '{1'b1, s, e, w, b, rl};
		@(negedge i_clk);
		i_sec.valid = 0;
		if (rl && s && armed && !pe && !pb && i_code_blank && i_data_blank)
			pw = 0;
		pe |= e;
		pw |= w;
		pb |= b;
		armed &= !w;
		repeat (2) @(negedge i_clk);
		chk(o_prot, {pe, pw, pb});
		chk(o_write_rel_armed, armed);
	endtask

	task automatic do_rst;
		i_rst_n = 0;
		i_prot_nv = '{pe, pw, pb};
		repeat (12) @(negedge i_clk);
		i_rst_n = 1;
		armed = pw;
		data_flash_access_enable = 0;
		repeat (3) @(negedge i_clk);
		chk(o_prot, {pe, pw, pb});
		chk(o_write_rel_armed, armed);
		chk(o_reg_rdata, 8'h00);
		$display("test reset done");
	endtask

	task automatic set_win(int s, int e);
		ws = s;
		we = e;
		i_win_set = 1;
		i_win_start = s[9:0];
		i_win_end = e[9:0];
		@(negedge i_clk);
		i_win_set = 0;
		@(negedge i_clk);
		chk({o_win_start, o_win_end}, {s[9:0], e[9:0]});
	endtask

	task automatic reg_wr(bit bw, logic [2:0] pos, logic [7:0] d);
		i_reg_wr = 1;
		i_reg_bit = bw;
		i_reg_bitpos = pos;
		i_reg_wdata = d;
		@(negedge i_clk);
		i_reg_wr = 0;
		if (!i_bg_rewrite && (!bw || pos == 0)) data_flash_access_enable = d[0];
		repeat (2) @(negedge i_clk);
		chk(o_reg_rdata, {7'h00, data_flash_access_enable});
	endtask

	task automatic df(logic [1:0] sz, bit f, bit e);
		i_df_acc = !f;
		i_df_fetch = f;
		i_df_size = sz;
		@(negedge i_clk);
		{i_df_acc, i_df_fetch} = 0;
		if (!(o_df_grant | o_df_err)) @(negedge i_clk);
		chk({o_df_grant, o_df_err}, {e, !e});
		@(negedge i_clk);
	endtask

	task automatic stop(bit e);
		i_stop_req = 1;
		@(negedge i_clk);
		i_stop_req = 0;
		if (!o_stop_ok) @(negedge i_clk);
		chk(o_stop_ok, e);
	endtask

	task automatic finish_test;
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// A hang is cut short long after the sequence should have ended
	initial begin
		#400000;
		failures++;
		finish_test();
	end

	initial begin
		{i_reg_wr, i_reg_bit, i_reg_bitpos, i_reg_wdata, i_win_set} = 0;
		{i_win_start, i_win_end, i_req, i_sec, i_self_prog_busy} = 0;
		{i_bg_rewrite, i_df_acc, i_df_fetch, i_df_size, i_stop_req} = 0;
		i_reg_addr = frg_pkg::DFL_CTRL_ADDR;
		i_fmode = frg_pkg::FRG_LS;
		i_prot_nv = '0;
		wipe = 1;
		r = $urandom(33137);
		do_rst();
		wipe = 0;
		// Random window and requests, then both window edges
		set_win($urandom_range(8, 1), 0);
		set_win(ws, ws + $urandom_range(3, 0));
		repeat (40) begin
			r = $urandom;
			do_req(1 + r[0], r[1], r[2], {6'h00, r[6:3], r[19:10]});
		end
		for (int b = ws - 1; b <= we + 1; b++)
			do_req(2, 0, 0, 20'(b) << 10);
		$display("test window done");
		// Write prohibition and its release conditions
		do_sec(1, 0, 1, 0, 0);
		do_req(2, 1, 0, 20'(ws) << 10);
		do_req(2, 0, 0, 20'(ws) << 10);
		do_sec(1, 0, 0, 0, 1);
		do_rst();
		set_win(0, 3);
		do_sec(0, 0, 0, 0, 1);
		do_sec(1, 0, 0, 0, 1);
		wipe = 1;
		@(negedge i_clk);
		wipe = 0;
		@(negedge i_clk);
		do_sec(1, 0, 0, 0, 1);
		do_sec(1, 0, 1, 0, 0);
		do_sec(1, 0, 0, 0, 1);
		do_rst();
		set_win(0, 3);
		do_sec(1, 0, 0, 0, 1);
		$display("test release done");
		// Erase and boot cluster 0 prohibitions
		do_sec(0, 1, 0, 0, 0);
		do_req(1, 1, 0, 20'h02000);
		do_req(1, 0, 0, 20'h00c00);
		do_req(2, 1, 0, 20'h02000);
		do_sec(1, 0, 0, 1, 0);
		do_req(1, 0, 0, 20'h00ffc);
		do_req(2, 1, 0, 20'h00800);
		do_req(2, 1, 0, 20'h01000);
		do_req(2, 0, 1, 20'h00000);
		do_sec(1, 0, 0, 0, 1);
		do_rst();
		$display("test security done");
		// Data flash enable, setup time and access gating
		reg_wr(0, 0, 8'hff);
		df(0, 0, 0);
		repeat (frg_pkg::SETUP_LS_CYC + 8) @(negedge i_clk);
		df(0, 0, 1);
		df(1, 0, 0);
		df(0, 1, 0);
		i_self_prog_busy = 1;
		df(0, 0, 0);
		i_self_prog_busy = 0;
		reg_wr(1, 0, 8'h00);
		df(0, 0, 0);
		reg_wr(1, 0, 8'h01);
		i_bg_rewrite = 1;
		repeat (4) @(negedge i_clk);
		reg_wr(0, 0, 8'h00);
		stop(0);
		i_bg_rewrite = 0;
		repeat (4) @(negedge i_clk);
		stop(1);
		// The high-speed mode, with its longer setup time, must stretch the setup wait
		i_fmode = frg_pkg::FRG_HS;
		reg_wr(1, 0, 8'h00);
		reg_wr(1, 0, 8'h01);
		repeat (frg_pkg::SETUP_LS_CYC + 8) @(negedge i_clk);
		df(0, 0, 0);
		repeat (frg_pkg::SETUP_HS_CYC - frg_pkg::SETUP_LS_CYC)
			@(negedge i_clk);
		df(0, 0, 1);
		$display("test data flash done");
		finish_test();
	end
endmodule
